/* File: core/video_test_pkg.sv */
// constants shared by the video crc and sense test logic
package video_test_pkg;

  // ---------------------------------------------------------------
  // register indexes
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SILICON_REVISION = 8'h01;
  localparam logic [7:0] IDX_SENSE_TEST = 8'h3a;
  localparam logic [7:0] IDX_CRC_LOW = 8'h3c;
  localparam logic [7:0] IDX_CRC_HIGH = 8'h3d;
  localparam logic [7:0] IDX_CRC_LINE_SELECT = 8'h3e;
  localparam logic [7:0] IDX_DEVICE_IDENT = 8'h3f;

  // ---------------------------------------------------------------
  // field layout and values
  // ---------------------------------------------------------------
  localparam int SENSE_DISABLE_BIT = 7;
  localparam logic [4:0] CRC_LINE_MAX = 5'h17;
  localparam int DAC_LINES = 24;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [4:0] LINE_SELECT_RESET = 5'h00;
  localparam logic [3:0] REV_MAJOR = 4'h0;
  localparam logic [3:0] REV_MINOR = 4'h0;
  // arbitrary identification value
  localparam logic [7:0] DEVICE_IDENT_CODE = 8'h5a;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

/* File: core/sync_two_ff.sv */
// two-flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync_two_ff (
  input wire logic i_ref_clk, // dot clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_ce, // clock enable
  input wire logic i_async, // pin level
  output logic o_sync // synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // first stage feeds only the second
  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (i_ce) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule

/* File: core/crc16_serial.sv */
// serial 16-bit crc shift register
`timescale 1ns/1ps
module crc16_serial (
  input wire logic i_ref_clk, // dot clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_ce, // clock enable
  input wire logic i_init, // reload seed
  input wire logic i_shift, // take one bit
  input wire logic i_bit, // data bit
  output logic [15:0] o_crc // running remainder
);
  import video_test_pkg::*;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // init beats shift so a new frame starts clean
  always_comb begin
    crc_nxt = crc_r;
    if (i_init) begin
      crc_nxt = CRC_SEED;
    end else if (i_shift) begin
      crc_nxt = {crc_r[14:0], 1'b0} ^
        ((crc_r[15] ^ i_bit) ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      crc_r <= CRC_SEED;
    end else if (i_ce) begin
      crc_r <= crc_nxt;
    end
  end

  assign o_crc = crc_r;
endmodule

/* File: core/video_crc_sense_test.sv */
// crc, monitor-sense and identification test logic of the palette
`timescale 1ns/1ps
module video_crc_sense_test (
  input wire logic i_ref_clk, // dot clock, 125 mhz
  input wire logic i_rst, // synchronous reset, high
  input wire logic i_ce, // clock enable
  input wire logic [7:0] i_reg_index, // register index
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic i_reg_wr, // write strobe, one cycle
  input wire logic i_reg_rd, // read strobe, one cycle
  output logic [7:0] o_reg_rdata, // read data, registered
  input wire logic [23:0] i_dac_data, // dac input data lines
  input wire logic i_hsync_n, // horizontal sync pin
  input wire logic i_system_port_blank, // blank, system port
  input wire logic i_legacy_port_blank, // blank, legacy port
  input wire logic i_blank_source_select, // 1 selects system port
  input wire logic i_red_current_out, // red comparator high
  input wire logic i_green_current_out, // green comparator high
  input wire logic i_blue_current_out, // blue comparator high
  output logic o_sense_n, // monitor sense, active low
  output logic o_crc_valid // a full-frame result is held
);
  import video_test_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic hs_n_s;
  logic sys_bl_s;
  logic leg_bl_s;
  logic sel_s;
  logic red_s;
  logic grn_s;
  logic blu_s;

  sync_two_ff u_sync_hs (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_hsync_n), .o_sync(hs_n_s));
  sync_two_ff u_sync_sbl (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_system_port_blank), .o_sync(sys_bl_s));
  sync_two_ff u_sync_lbl (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_legacy_port_blank), .o_sync(leg_bl_s));
  sync_two_ff u_sync_sel (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_blank_source_select), .o_sync(sel_s));
  sync_two_ff u_sync_r (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_red_current_out), .o_sync(red_s));
  sync_two_ff u_sync_g (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_green_current_out), .o_sync(grn_s));
  sync_two_ff u_sync_b (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_async(i_blue_current_out), .o_sync(blu_s));

  // the dac bus is sampled as a word; the source holds it steady
  // during active video so a plain two-stage pipe is enough
  logic [23:0] dac_m_r;
  logic [23:0] dac_m_nxt;
  logic [23:0] dac_s_r;
  logic [23:0] dac_s_nxt;

  // first stage feeds only the second, as in the bit synchroniser
  always_comb begin
    dac_m_nxt = i_dac_data;
    dac_s_nxt = dac_m_r;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic blank_s;
  logic blank_d_r;
  logic blank_d_nxt;
  logic hs_d_r;
  logic hs_d_nxt;
  logic [1:0] hs_cnt_r;
  logic [1:0] hs_cnt_nxt;
  logic frame_seen_r;
  logic frame_seen_nxt;
  logic crc_valid_r;
  logic crc_valid_nxt;
  logic [15:0] crc_hold_r;
  logic [15:0] crc_hold_nxt;
  logic [4:0] line_sel_r;
  logic [4:0] line_sel_nxt;
  logic sense_dis_r;
  logic sense_dis_nxt;
  logic [2:0] sense_bits_r;
  logic [2:0] sense_bits_nxt;
  logic sense_n_r;
  logic sense_n_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic hs_fall;
  logic blank_fall;
  logic frame_update;
  logic dac_bit;
  logic [15:0] crc_run;

  // ---------------------------------------------------------------
  // blank selection and edge detection
  // ---------------------------------------------------------------
  // blank is active low; falling edge opens the blanking interval
  always_comb begin
    blank_s = sel_s ? sys_bl_s : leg_bl_s;
    blank_fall = blank_d_r & ~blank_s;
    hs_fall = hs_d_r & ~hs_n_s;
    blank_d_nxt = blank_s;
    hs_d_nxt = hs_n_s;
  end

  // ---------------------------------------------------------------
  // vertical retrace detection
  // ---------------------------------------------------------------
  // a second hsync inside one blanking interval marks retrace;
  // the count clears whenever active video returns
  always_comb begin
    hs_cnt_nxt = hs_cnt_r;
    frame_update = 1'b0;
    if (blank_s) begin
      hs_cnt_nxt = 2'd0;
    end else if (hs_fall) begin
      if (hs_cnt_r == 2'd1) begin
        frame_update = 1'b1;
        hs_cnt_nxt = 2'd2;
      end else if (hs_cnt_r == 2'd0) begin
        hs_cnt_nxt = 2'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // crc datapath
  // ---------------------------------------------------------------
  assign dac_bit = dac_s_r[line_sel_r];

  crc16_serial u_crc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_init(frame_update),
    .i_shift(blank_s),
    .i_bit(dac_bit),
    .o_crc(crc_run)
  );

  // the first update only closes a partial frame, so validity
  // waits for the second one
  always_comb begin
    crc_hold_nxt = crc_hold_r;
    frame_seen_nxt = frame_seen_r;
    crc_valid_nxt = crc_valid_r;
    if (frame_update) begin
      crc_hold_nxt = crc_run;
      frame_seen_nxt = 1'b1;
      crc_valid_nxt = frame_seen_r;
    end
    // a new line choice restarts the full-frame wait
    if (i_reg_wr && i_reg_index == IDX_CRC_LINE_SELECT) begin
      frame_seen_nxt = 1'b0;
      crc_valid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sense capture
  // ---------------------------------------------------------------
  always_comb begin
    sense_bits_nxt = sense_bits_r;
    sense_n_nxt = sense_n_r;
    if (blank_fall) begin
      if (sense_dis_r) begin
        sense_bits_nxt = 3'b000;
        sense_n_nxt = 1'b1;
      end else begin
        sense_bits_nxt = {red_s, grn_s, blu_s};
        sense_n_nxt = ~(red_s | grn_s | blu_s);
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // out-of-range line values are ignored; identity and revision
  // have no write path at all
  always_comb begin
    line_sel_nxt = line_sel_r;
    sense_dis_nxt = sense_dis_r;
    if (i_reg_wr) begin
      if (i_reg_index == IDX_CRC_LINE_SELECT) begin
        if (i_reg_wdata[4:0] <= CRC_LINE_MAX &&
            i_reg_wdata[7:5] == 3'b000) begin
          line_sel_nxt = i_reg_wdata[4:0];
        end
      end else if (i_reg_index == IDX_SENSE_TEST) begin
        sense_dis_nxt = i_reg_wdata[SENSE_DISABLE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      if (i_reg_index == IDX_SILICON_REVISION) begin
        rdata_nxt = {REV_MAJOR, REV_MINOR};
      end else if (i_reg_index == IDX_SENSE_TEST) begin
        rdata_nxt = {sense_dis_r, 4'h0, sense_bits_r};
      end else if (i_reg_index == IDX_CRC_LOW) begin
        rdata_nxt = crc_hold_r[7:0];
      end else if (i_reg_index == IDX_CRC_HIGH) begin
        rdata_nxt = crc_hold_r[15:8];
      end else if (i_reg_index == IDX_CRC_LINE_SELECT) begin
        rdata_nxt = {3'b000, line_sel_r};
      end else if (i_reg_index == IDX_DEVICE_IDENT) begin
        rdata_nxt = DEVICE_IDENT_CODE;
      end else begin
        rdata_nxt = READ_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // input pipe; cleared so no stale pixel reaches the crc
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dac_m_r <= 24'h000000;
      dac_s_r <= 24'h000000;
    end else if (i_ce) begin
      dac_m_r <= dac_m_nxt;
      dac_s_r <= dac_s_nxt;
    end
  end

  // edge history; hsync history resets low like its synchroniser
  // so the release of reset cannot look like a sync pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      blank_d_r <= 1'b0;
      hs_d_r <= 1'b0;
    end else if (i_ce) begin
      blank_d_r <= blank_d_nxt;
      hs_d_r <= hs_d_nxt;
    end
  end

  // retrace pulse count
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hs_cnt_r <= 2'd0;
    end else if (i_ce) begin
      hs_cnt_r <= hs_cnt_nxt;
    end
  end

  // held remainder and its validity
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      frame_seen_r <= 1'b0;
      crc_valid_r <= 1'b0;
      crc_hold_r <= 16'h0000;
    end else if (i_ce) begin
      frame_seen_r <= frame_seen_nxt;
      crc_valid_r <= crc_valid_nxt;
      crc_hold_r <= crc_hold_nxt;
    end
  end

  // latched sense results
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sense_bits_r <= 3'b000;
      sense_n_r <= 1'b1;
    end else if (i_ce) begin
      sense_bits_r <= sense_bits_nxt;
      sense_n_r <= sense_n_nxt;
    end
  end

  // writable fields
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      line_sel_r <= LINE_SELECT_RESET;
      sense_dis_r <= 1'b0;
    end else if (i_ce) begin
      line_sel_r <= line_sel_nxt;
      sense_dis_r <= sense_dis_nxt;
    end
  end

  // read data holds until the next read
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_r <= READ_ZERO;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_sense_n = sense_n_r;
  assign o_crc_valid = crc_valid_r;
endmodule

/* File: tb/video_crc_sense_test_properties.sv */
// port assertions for the crc and sense test block
`timescale 1ns/1ps
module video_crc_sense_test_properties import video_test_pkg::*; (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst, // reset
  input wire logic [7:0] i_reg_index, // index
  input wire logic [7:0] i_reg_wdata, // data
  input wire logic i_reg_wr, // write
  input wire logic i_reg_rd, // read
  input wire logic [7:0] o_reg_rdata, // read data
  input wire logic i_system_port_blank, // blank a
  input wire logic i_legacy_port_blank, // blank b
  input wire logic i_blank_source_select, // blank mux
  input wire logic i_red_current_out, // red
  input wire logic i_green_current_out, // green
  input wire logic i_blue_current_out, // blue
  input wire logic o_sense_n, // sense
  input wire logic o_crc_valid // valid
);
  logic blk, cmp, dis_r, dis_nxt;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // helpers and properties
  // ---------------------------------------------------------------
  // selected blank pin and any comparator high
  assign blk = i_blank_source_select ? i_system_port_blank :
    i_legacy_port_blank;
  assign cmp = i_red_current_out | i_green_current_out | i_blue_current_out;
  // shadow of the disable bit, so disabled spans are skipped
  always_comb begin
    dis_nxt = dis_r;
    if (i_reg_wr && i_reg_index == IDX_SENSE_TEST) begin
      dis_nxt = i_reg_wdata[SENSE_DISABLE_BIT];
    end
  end
  always_ff @(posedge i_ref_clk) begin
    dis_r <= i_rst ? 1'b0 : dis_nxt;
  end
  sequence s_blank_fall;
    $fell(blk) && cmp && !dis_r;
  endsequence
  sequence s_sense_low;
    ##[2:4] !o_sense_n;
  endsequence
  property p_ident;
    i_reg_rd && i_reg_index == IDX_DEVICE_IDENT |=>
      o_reg_rdata == DEVICE_IDENT_CODE;
  endproperty
  property p_rev;
    i_reg_rd && i_reg_index == IDX_SILICON_REVISION |=>
      o_reg_rdata == {REV_MAJOR, REV_MINOR};
  endproperty
  property p_reset;
    $past(i_rst) |-> o_sense_n && !o_crc_valid && o_reg_rdata == READ_ZERO;
  endproperty
  property p_sense_latch;
    s_blank_fall |-> s_sense_low;
  endproperty
  property p_sense_fall;
    $fell(o_sense_n) && !$past(dis_r) |-> !$past(blk) && !$past(blk, 2);
  endproperty
  property p_valid_clear;
    i_reg_wr && i_reg_index == IDX_CRC_LINE_SELECT && i_reg_wdata[7:5] == 0
      && i_reg_wdata[4:0] <= CRC_LINE_MAX |=> !o_crc_valid;
  endproperty
  property p_valid_fall;
    $fell(o_crc_valid) |->
      $past(i_reg_wr) && $past(i_reg_index) == IDX_CRC_LINE_SELECT;
  endproperty
  property p_valid_rise;
    $rose(o_crc_valid) |-> !$past(blk) && !$past(blk, 2);
  endproperty
  a_ident: assert property (p_ident) else $error("ident bad");
  a_rev: assert property (p_rev) else $error("revision bad");
  a_reset: assert property (p_reset) else $error("reset bad");
  a_sense_latch: assert property (p_sense_latch)
    else $error("sense not low");
  a_sense_fall: assert property (p_sense_fall)
    else $error("sense fell outside blank");
  a_valid_clear: assert property (p_valid_clear)
    else $error("valid not cleared");
  a_valid_fall: assert property (p_valid_fall)
    else $error("valid fell");
  a_valid_rise: assert property (p_valid_rise)
    else $error("valid rose outside blank");
endmodule
bind video_crc_sense_test video_crc_sense_test_properties u_props (
  .i_ref_clk, .i_rst, .i_reg_index, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .i_system_port_blank, .i_legacy_port_blank,
  .i_blank_source_select, .i_red_current_out, .i_green_current_out,
  .i_blue_current_out, .o_sense_n, .o_crc_valid);

/* File: tb/host_model.sv */
// host processor model on the indexed register port
`timescale 1ns/1ps
module host_model (
  input wire logic i_ref_clk, // clock
  input wire logic [7:0] i_reg_rdata, // read data
  output logic [7:0] o_reg_index = 8'h00, // index
  output logic [7:0] o_reg_wdata = 8'h00, // write data
  output logic o_reg_wr = 1'b0, // write strobe
  output logic o_reg_rd = 1'b0 // read strobe
);
  import video_test_pkg::*;
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one access held over one edge; index and data flip on release
  // so a stale value never passes for a live one
  task automatic access(input logic wr, input logic [7:0] idx,
      input logic [7:0] data, output logic [7:0] rdata);
    @(posedge i_ref_clk);
    #1;
    o_reg_index = idx;
    o_reg_wdata = data;
    o_reg_wr = wr;
    o_reg_rd = !wr;
    @(posedge i_ref_clk);
    #1;
    rdata = i_reg_rdata;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_index = ~idx;
    o_reg_wdata = ~data;
  endtask
  // disabling sense zeroes the bits below the disable bit at the next blank fall
  task automatic sense_off(output logic [7:0] rdata);
    access(1'b1, IDX_SENSE_TEST, 8'h80, rdata);
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the crc and sense test block
`timescale 1ns/1ps
module testbench;
  import video_test_pkg::*;
  typedef struct {logic wr; logic [7:0] idx, wd, exp;} row_type;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_hsync_n = 1'b1;
  logic i_system_port_blank = 1'b1, i_legacy_port_blank = 1'b1;
  logic i_blank_source_select = 1'b1, o_sense_n, o_crc_valid;
  logic i_red_current_out = 1'b0, i_green_current_out = 1'b0;
  logic i_blue_current_out = 1'b0, i_reg_wr, i_reg_rd;
  logic i_ce = 1'b1;
  logic [7:0] i_reg_index, i_reg_wdata, o_reg_rdata, rd_val;
  logic [23:0] i_dac_data = 24'h5a3c96;
  logic [15:0] crc_exp = CRC_SEED;
  logic [2:0] cmp;
  logic [4:0] sel;
  int fail_count = 0;
  int checks_done = 0;
  row_type rows [6] = '{
    '{1'b1, IDX_SILICON_REVISION, 8'hff, {REV_MAJOR, REV_MINOR}},
    '{1'b1, IDX_DEVICE_IDENT, 8'ha5, DEVICE_IDENT_CODE},
    '{1'b0, IDX_CRC_LINE_SELECT, 8'h00, 8'h00},
    '{1'b1, IDX_CRC_LINE_SELECT, 8'h17, 8'h17},
    '{1'b1, IDX_CRC_LINE_SELECT, 8'h18, 8'h17},
    '{1'b1, 8'h55, 8'h3c, READ_ZERO}};
  // ---------------------------------------------------------------
  // clock, parts and tasks
  // ---------------------------------------------------------------
  always #4 i_ref_clk = ~i_ref_clk;
  video_crc_sense_test DUT (.i_ref_clk, .i_rst, .i_ce, .i_reg_index,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_dac_data,
    .i_hsync_n, .i_system_port_blank, .i_legacy_port_blank,
    .i_blank_source_select, .i_red_current_out, .i_green_current_out,
    .i_blue_current_out, .o_sense_n, .o_crc_valid);
  host_model u_host (.i_ref_clk, .i_reg_rdata(o_reg_rdata),
    .o_reg_index(i_reg_index), .o_reg_wdata(i_reg_wdata),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one dot; blanked dots scramble the data so leaks show in the crc
  task automatic dot(input logic blank_n, input logic hs_n);
    logic fb;
    @(posedge i_ref_clk);
    #1;
    i_system_port_blank = blank_n;
    i_legacy_port_blank = blank_n;
    i_hsync_n = hs_n;
    i_dac_data = blank_n ? {i_dac_data[22:0], ~^i_dac_data[23:20]} :
      ~i_dac_data;
    fb = i_dac_data[sel] ^ crc_exp[15];
    if (blank_n) begin
      crc_exp = {crc_exp[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
  endtask
  // blank-low span holding a number of sync pulses
  task automatic gap(input int pulses);
    repeat (pulses) begin
      repeat (3) dot(1'b0, 1'b1);
      repeat (2) dot(1'b0, 1'b0);
    end
    repeat (4) dot(1'b0, 1'b1);
  endtask
  // comparators settle well before the blank edge and stay put
  task automatic sense_latch(input logic src);
    @(posedge i_ref_clk);
    #1;
    i_blank_source_select = src;
    {i_red_current_out, i_green_current_out, i_blue_current_out} = cmp;
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_system_port_blank = !src;
    i_legacy_port_blank = src;
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_system_port_blank = 1'b1;
    i_legacy_port_blank = 1'b1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check(16'(o_sense_n), 16'h0001);
    u_host.access(1'b0, IDX_SENSE_TEST, 8'h00, rd_val);
    check(16'(rd_val[7]), 16'h0000);
    foreach (rows[i]) begin
      u_host.access(rows[i].wr, rows[i].idx, rows[i].wd, rd_val);
      u_host.access(1'b0, rows[i].idx, 8'h00, rd_val);
      check(16'(rd_val), 16'(rows[i].exp));
    end
    for (int k = 0; k < 5; k++) begin
      cmp = (k < 3) ? 3'b001 << k : {3{k == 4}};
      if (k == 4) begin
        u_host.sense_off(rd_val);
      end
      sense_latch(k[0]);
      u_host.access(1'b0, IDX_SENSE_TEST, 8'h00, rd_val);
      check(16'(rd_val[6:0]), 16'(k == 4 ? 3'b000 : cmp));
      check(16'(rd_val[7]), 16'(k == 4));
      check(16'(o_sense_n), 16'(k == 4 || cmp == 0));
    end
    u_host.access(1'b1, IDX_SENSE_TEST, 8'h00, rd_val);
    // a write while the clock enable is low must leave no trace
    i_ce = 1'b0;
    u_host.access(1'b1, IDX_CRC_LINE_SELECT, 8'h05, rd_val);
    i_ce = 1'b1;
    u_host.access(1'b0, IDX_CRC_LINE_SELECT, 8'h00, rd_val);
    check(16'(rd_val), 16'(CRC_LINE_MAX));
    for (int s = 0; s < 2; s++) begin
      sel = (s == 0) ? CRC_LINE_MAX : 5'h00;
      u_host.access(1'b1, IDX_CRC_LINE_SELECT, 8'(sel), rd_val);
      check(16'(o_crc_valid), 16'h0000);
      // active dots close the previous blank span so this one counts
      repeat (4) dot(1'b1, 1'b1);
      gap(3);
      crc_exp = CRC_SEED;
      repeat (3) begin
        gap(1);
        repeat (16) dot(1'b1, 1'b1);
      end
      check(16'(o_crc_valid), 16'h0000);
      gap(3);
      check(16'(o_crc_valid), 16'h0001);
      u_host.access(1'b0, IDX_CRC_LOW, 8'h00, rd_val);
      check(16'(rd_val), 16'(crc_exp[7:0]));
      u_host.access(1'b0, IDX_CRC_HIGH, 8'h00, rd_val);
      check(16'(rd_val), 16'(crc_exp[15:8]));
    end
    tally_and_finish();
  end
endmodule
